// file: rtl/urt_uart.sv
// Functional notes
// RQ1 - software ends bursts only after shift idle
// RQ2 - queued frame still sent, then done flags clear
// RQ3 - receiver arms after module then receive enable
// RQ4 - reception begins on start bit at baud
// RQ5 - stop bit raises done, loads buffer
// RQ6 - disabled receiver idles, buffer kept, no irqs
// RQ7 - clearing receive enable aborts frame silently
// RQ8 - overrun flags, drops frame, raises selected irq
// RQ9 - parity or framing error still loads buffer
// RQ10 - merge bit routes errors to done irq
// RQ11 - error flags set with their irq
// RQ12 - reading error status returns and clears flags
// RQ13 - parity mismatch sets parity error
// RQ14 - missing stop bit sets framing error
// RQ15 - frame done while buffer unread is overrun
// RQ16 - single stop bit assumed, second ignored
// RQ17 - software reads buffer after every frame
// RQ18 - even parity transmit bit makes count even
// RQ19 - even parity receive odd count is error
// RQ20 - odd parity transmit bit makes count odd
// RQ21 - odd parity receive even count is error
// RQ22 - zero parity sends 0, never checks
// RQ23 - no parity omits bit, never errors
// RQ24 - error set beats clear on read
`timescale 1ns/10ps
module urt_uart (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_rxd,
   output logic             o_txd,
   output logic             o_tx_done_irq,
   output logic             o_rx_done_irq,
   output logic             o_rx_error_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   ////////////////////////////////////////////////////////////////////////////////
   // register bus
   logic [5:0]  ctrl_q, ctrl_d;
   logic [7:0]  baud_q, baud_d;
   logic [7:0]  txbuf_q, txbuf_d;
   logic        txfull_q, txfull_d;
   logic [7:0]  rxbuf_q, rxbuf_d, rx_sh_q, rx_sh_d;
   logic        rxfull_q, rxfull_d;
   logic [2:0]  err_q, err_d;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;
   logic        acc, mod_en, tx_en, rd_rxbuf, rd_err, tx_load, rx_fin, rx_keep;
   logic [2:0]  rx_err;
   urt_pkg::urt_par_t par_mode;
   urt_pkg::urt_st_t  tx_st_q, rx_st_q;

   assign acc      = i_psel & i_penable & o_pready;
   assign mod_en   = ctrl_q[urt_pkg::CTRL_MOD];
   assign tx_en    = mod_en & ctrl_q[urt_pkg::CTRL_TX];
   assign par_mode = urt_pkg::urt_par_t'(ctrl_q[urt_pkg::CTRL_PAR +: 2]);
   assign rd_rxbuf = acc & ~i_pwrite & (i_paddr == urt_pkg::ADDR_RXBUF);
   assign rd_err   = acc & ~i_pwrite & (i_paddr == urt_pkg::ADDR_RXERR);

   always_comb begin
      ctrl_d    = ctrl_q;
      baud_d    = baud_q;
      txbuf_d   = txbuf_q;
      txfull_d  = txfull_q & ~tx_load;
      rxbuf_d   = rxbuf_q;
      rxfull_d  = rxfull_q & ~rd_rxbuf;
      err_d     = err_q;
      prdata_d  = o_prdata;
      pready_d  = i_psel & ~i_penable;
      pslverr_d = 1'b0;
      if (i_psel & ~i_penable) begin
         prdata_d = 32'h0000_0000;
         if (i_paddr == urt_pkg::ADDR_CTRL) begin
            prdata_d[5:0] = ctrl_q;
         end else if (i_paddr == urt_pkg::ADDR_BAUD) begin
            prdata_d[7:0] = baud_q;
         end else if (i_paddr == urt_pkg::ADDR_TXBUF) begin
            prdata_d[7:0] = txbuf_q;
         end else if (i_paddr == urt_pkg::ADDR_TXSTAT) begin
            prdata_d[urt_pkg::STAT_BUF] = txfull_q;
            prdata_d[urt_pkg::STAT_SHF] = (tx_st_q != urt_pkg::ST_IDLE)
                                        & ~((tx_st_q == urt_pkg::ST_STOP) & ~txfull_q); // RQ2
         end else if (i_paddr == urt_pkg::ADDR_RXBUF) begin
            prdata_d[7:0] = rxbuf_q;
         end else if (i_paddr == urt_pkg::ADDR_RXERR) begin
            prdata_d[2:0] = err_q;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      // only the flags the reader saw are cleared; later ones survive
      if (rd_err) begin
         err_d = err_q & ~o_prdata[2:0]; // RQ12
      end
      if (acc & i_pwrite) begin
         if (i_paddr == urt_pkg::ADDR_CTRL) begin
            ctrl_d = i_pwdata[5:0];
         end else if (i_paddr == urt_pkg::ADDR_BAUD) begin
            baud_d = i_pwdata[7:0];
         end else if (i_paddr == urt_pkg::ADDR_TXBUF) begin
            // a write into a full buffer is dropped rather than corrupting
            if (tx_en & ~txfull_q) begin
               txbuf_d  = i_pwdata[7:0];
               txfull_d = 1'b1;
            end
         end
      end
      if (rx_fin) begin
         err_d = err_d | rx_err; // RQ11 RQ24
         if (rx_keep) begin
            rxbuf_d  = rx_sh_q; // RQ5 RQ9
            rxfull_d = 1'b1;
         end
      end
      // clearing the module enable initialises both directions
      if (!mod_en) begin
         txfull_d = 1'b0;
         rxfull_d = 1'b0;
         err_d    = 3'h0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q    <= urt_pkg::CTRL_RST;
         baud_q    <= urt_pkg::BAUD_RST;
         txbuf_q   <= urt_pkg::TXBUF_RST;
         txfull_q  <= 1'b0;
         rxbuf_q   <= 8'h00;
         rxfull_q  <= 1'b0;
         err_q     <= 3'h0;
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         baud_q    <= baud_d;
         txbuf_q   <= txbuf_d;
         txfull_q  <= txfull_d;
         rxbuf_q   <= rxbuf_d;
         rxfull_q  <= rxfull_d;
         err_q     <= err_d;
         o_prdata  <= prdata_d;
         o_pready  <= pready_d;
         o_pslverr <= pslverr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmitter
   urt_pkg::urt_st_t tx_st_d;
   logic [8:0] tx_cnt_q, tx_cnt_d, bit_len;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic [2:0] tx_bit_q, tx_bit_d;
   logic       txd_d, tx_irq_d, tx_tick;

   // one bit lasts one counter period of 2k base cycles
   assign bit_len = {baud_q, 1'b0} - 9'h001;
   assign tx_tick = (tx_cnt_q == 9'h000);
   assign tx_load = tx_en & txfull_q
                  & ((tx_st_q == urt_pkg::ST_IDLE) | ((tx_st_q == urt_pkg::ST_STOP) & tx_tick));

   always_comb begin
      tx_st_d  = tx_st_q;
      tx_cnt_d = tx_tick ? bit_len : tx_cnt_q - 9'h001;
      tx_sh_d  = tx_sh_q;
      tx_bit_d = tx_bit_q;
      txd_d    = o_txd;
      tx_irq_d = 1'b0;
      if (tx_load) begin
         tx_st_d  = urt_pkg::ST_START; // RQ2
         tx_sh_d  = txbuf_q;
         tx_cnt_d = bit_len;
         txd_d    = 1'b0;
      end else if (tx_tick) begin
         case (tx_st_q)
            urt_pkg::ST_START: begin
               tx_st_d  = urt_pkg::ST_DATA;
               tx_bit_d = 3'h0;
               txd_d    = tx_sh_q[0];
            end
            urt_pkg::ST_DATA: begin
               if (tx_bit_q == urt_pkg::LAST_BIT) begin
                  if (par_mode == urt_pkg::PAR_NONE) begin
                     tx_st_d  = urt_pkg::ST_STOP; // RQ23
                     txd_d    = 1'b1;
                     tx_irq_d = 1'b1;
                  end else begin
                     tx_st_d = urt_pkg::ST_PAR;
                     case (par_mode)
                        urt_pkg::PAR_EVEN: txd_d = ^tx_sh_q;  // RQ18
                        urt_pkg::PAR_ODD:  txd_d = ~^tx_sh_q; // RQ20
                        default:           txd_d = 1'b0;      // RQ22
                     endcase
                  end
               end else begin
                  tx_bit_d = tx_bit_q + 3'h1;
                  // rotate, so all data bits are still there for the parity bit
                  tx_sh_d  = {tx_sh_q[0], tx_sh_q[7:1]};
                  txd_d    = tx_sh_q[1];
               end
            end
            urt_pkg::ST_PAR: begin
               // done is raised as the stop bit begins
               tx_st_d  = urt_pkg::ST_STOP;
               txd_d    = 1'b1;
               tx_irq_d = 1'b1;
            end
            urt_pkg::ST_STOP: begin
               tx_st_d = urt_pkg::ST_IDLE;
            end
            default: begin
               tx_st_d = urt_pkg::ST_IDLE;
               txd_d   = 1'b1;
            end
         endcase
      end
      if (!tx_en) begin
         tx_st_d  = urt_pkg::ST_IDLE;
         tx_irq_d = 1'b0;
         txd_d    = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_st_q       <= urt_pkg::ST_IDLE;
         tx_cnt_q      <= 9'h000;
         tx_sh_q       <= 8'h00;
         tx_bit_q      <= 3'h0;
         o_txd         <= 1'b1;
         o_tx_done_irq <= 1'b0;
      end else begin
         tx_st_q       <= tx_st_d;
         tx_cnt_q      <= tx_cnt_d;
         tx_sh_q       <= tx_sh_d;
         tx_bit_q      <= tx_bit_d;
         o_txd         <= txd_d;
         o_tx_done_irq <= tx_irq_d;
      end
   end

   tx_done_a : assert property ((tx_st_q == urt_pkg::ST_STOP) && ($past(tx_st_q) != urt_pkg::ST_STOP)
      |-> o_tx_done_irq && o_txd) else $error("done not raised with stop bit"); // RQ2
   tx_queue_a : assert property ((tx_st_q == urt_pkg::ST_STOP) && tx_tick && txfull_q && tx_en
      |=> (tx_st_q == urt_pkg::ST_START) && !o_txd && !txfull_q) else $error("queued frame lost"); // RQ2
   tx_parity_a : assert property ((tx_st_q == urt_pkg::ST_PAR) && (par_mode == urt_pkg::PAR_ZERO)
      |-> !o_txd) else $error("zero parity bit not 0"); // RQ22

   ////////////////////////////////////////////////////////////////////////////////
   // receiver
   urt_pkg::urt_st_t rx_st_d;
   logic [8:0] rx_cnt_q, rx_cnt_d;
   logic [2:0] rx_bit_q, rx_bit_d;
   logic       rx_par_q, rx_par_d, armed_q, armed_d, ren_old_q;
   logic       rxd_s1_q, rxd_s2_q, rxd_old_q, rx_tick, rx_irq_err;
   logic       rx_done_d, rx_errirq_d, rx_ren;

   assign rx_ren  = ctrl_q[urt_pkg::CTRL_RX];
   assign rx_tick = (rx_cnt_q == 9'h000);
   assign rx_fin  = armed_q & rx_tick & (rx_st_q == urt_pkg::ST_STOP); // RQ16
   assign rx_err[urt_pkg::ERR_PE] = ((par_mode == urt_pkg::PAR_EVEN) & (^rx_sh_q ^ rx_par_q))
                                  | ((par_mode == urt_pkg::PAR_ODD) & ~(^rx_sh_q ^ rx_par_q)); // RQ13 RQ19 RQ21
   assign rx_err[urt_pkg::ERR_FE] = ~rxd_s2_q; // RQ14
   assign rx_err[urt_pkg::ERR_OV] = rxfull_q & ~rd_rxbuf; // RQ15
   assign rx_keep    = ~rx_err[urt_pkg::ERR_OV]; // RQ8
   assign rx_irq_err = |rx_err;

   always_comb begin
      // enable must rise while the module is on, or in the same write
      armed_d     = mod_en & rx_ren & (armed_q | ~ren_old_q); // RQ3
      rx_st_d     = rx_st_q;
      rx_cnt_d    = rx_tick ? bit_len : rx_cnt_q - 9'h001;
      rx_sh_d     = rx_sh_q;
      rx_bit_d    = rx_bit_q;
      rx_par_d    = rx_par_q;
      rx_done_d   = 1'b0;
      rx_errirq_d = 1'b0;
      case (rx_st_q)
         urt_pkg::ST_IDLE: begin
            if (rxd_old_q & ~rxd_s2_q) begin
               rx_st_d  = urt_pkg::ST_START; // RQ4
               rx_cnt_d = {1'b0, baud_q} - 9'h001;
            end
         end
         urt_pkg::ST_START: begin
            if (rx_tick) begin
               // a start bit gone high by mid-bit was a glitch
               rx_st_d  = rxd_s2_q ? urt_pkg::ST_IDLE : urt_pkg::ST_DATA;
               rx_bit_d = 3'h0;
            end
         end
         urt_pkg::ST_DATA: begin
            if (rx_tick) begin
               rx_sh_d  = {rxd_s2_q, rx_sh_q[7:1]};
               rx_bit_d = rx_bit_q + 3'h1;
               if (rx_bit_q == urt_pkg::LAST_BIT) begin
                  rx_st_d = (par_mode == urt_pkg::PAR_NONE) ? urt_pkg::ST_STOP
                                                             : urt_pkg::ST_PAR; // RQ23
               end
            end
         end
         urt_pkg::ST_PAR: begin
            if (rx_tick) begin
               rx_par_d = rxd_s2_q;
               rx_st_d  = urt_pkg::ST_STOP;
            end
         end
         default: begin
            // back to idle at mid stop bit, so a second stop bit is just idle line
            if (rx_tick) begin
               rx_st_d     = urt_pkg::ST_IDLE;
               rx_done_d   = ~rx_irq_err | ctrl_q[urt_pkg::CTRL_MRG]; // RQ10
               rx_errirq_d = rx_irq_err & ~ctrl_q[urt_pkg::CTRL_MRG]; // RQ8 RQ9 RQ10
            end
         end
      endcase
      if (!armed_q) begin
         rx_st_d     = urt_pkg::ST_IDLE; // RQ6 RQ7
         rx_done_d   = 1'b0;
         rx_errirq_d = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_st_q        <= urt_pkg::ST_IDLE;
         rx_cnt_q       <= 9'h000;
         rx_sh_q        <= 8'h00;
         rx_bit_q       <= 3'h0;
         rx_par_q       <= 1'b0;
         armed_q        <= 1'b0;
         ren_old_q      <= 1'b0;
         rxd_s1_q       <= 1'b1;
         rxd_s2_q       <= 1'b1;
         rxd_old_q      <= 1'b1;
         o_rx_done_irq  <= 1'b0;
         o_rx_error_irq <= 1'b0;
      end else begin
         rx_st_q        <= rx_st_d;
         rx_cnt_q       <= rx_cnt_d;
         rx_sh_q        <= rx_sh_d;
         rx_bit_q       <= rx_bit_d;
         rx_par_q       <= rx_par_d;
         armed_q        <= armed_d;
         ren_old_q      <= rx_ren;
         rxd_s1_q       <= i_rxd;
         rxd_s2_q       <= rxd_s1_q;
         rxd_old_q      <= rxd_s2_q;
         o_rx_done_irq  <= rx_done_d;
         o_rx_error_irq <= rx_errirq_d;
      end
   end

   rx_gate_a : assert property (!armed_q |=> (rx_st_q == urt_pkg::ST_IDLE) && !o_rx_done_irq
      && !o_rx_error_irq) else $error("disabled receiver active"); // RQ6
   rx_hold_a : assert property (!armed_q && mod_en && !rd_err
      |=> $stable(rxbuf_q) && $stable(err_q)) else $error("disabled receiver changed state"); // RQ7
   rx_load_a : assert property (rx_fin && rx_keep |=> (rxbuf_q == $past(rx_sh_q)) && rxfull_q
      && (o_rx_done_irq || o_rx_error_irq)) else $error("frame not loaded"); // RQ5
   rx_overrun_a : assert property (rx_fin && !rx_keep |=> err_q[urt_pkg::ERR_OV] && $stable(rxbuf_q))
      else $error("overrun mishandled"); // RQ8
   rx_merge_a : assert property (rx_fin && rx_irq_err && ctrl_q[urt_pkg::CTRL_MRG]
      |=> o_rx_done_irq && !o_rx_error_irq) else $error("merged error not on done"); // RQ10
   err_sync_a : assert property ($rose(err_q[urt_pkg::ERR_FE]) |-> o_rx_done_irq || o_rx_error_irq)
      else $error("error flag without irq"); // RQ11
   rd_clear_a : assert property (rd_err && !rx_fin && mod_en |=> (err_q & $past(o_prdata[2:0])) == 3'h0)
      else $error("read did not clear flags"); // RQ12
   set_wins_a : assert property (rd_err && rx_fin && rx_err[urt_pkg::ERR_FE] |=> err_q[urt_pkg::ERR_FE])
      else $error("new error lost on read"); // RQ24
endmodule

// file: rtl/urt_pkg.sv
package urt_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BAUD   = 8'h04;
   localparam logic [7:0] ADDR_TXBUF  = 8'h08;
   localparam logic [7:0] ADDR_TXSTAT = 8'h0c;
   localparam logic [7:0] ADDR_RXBUF  = 8'h10;
   localparam logic [7:0] ADDR_RXERR  = 8'h14;
   // control field positions
   localparam int CTRL_MOD = 0;
   localparam int CTRL_TX  = 1;
   localparam int CTRL_RX  = 2;
   localparam int CTRL_MRG = 3;
   localparam int CTRL_PAR = 4;
   // status field positions
   localparam int ERR_PE   = 0;
   localparam int ERR_FE   = 1;
   localparam int ERR_OV   = 2;
   localparam int STAT_BUF = 0;
   localparam int STAT_SHF = 1;
   // reset values and last data bit index
   localparam logic [5:0] CTRL_RST  = 6'h00;
   localparam logic [7:0] BAUD_RST  = 8'hff;
   localparam logic [7:0] TXBUF_RST = 8'hff;
   localparam logic [2:0] LAST_BIT  = 3'h7;

   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ZERO = 2'b01,
      PAR_ODD  = 2'b10,
      PAR_EVEN = 2'b11
   } urt_par_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_DATA  = 3'b010,
      ST_PAR   = 3'b011,
      ST_STOP  = 3'b100
   } urt_st_t;
endpackage

// file: tb/urt_remote.sv
`timescale 1ns/10ps
module urt_remote #(
   parameter int BT = 8
) (
   input  wire logic i_clk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   initial o_rxd = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // flip and stop let a caller break parity or framing on purpose
   task automatic send(input logic [7:0] d, input urt_pkg::urt_par_t p, input logic fl,
                       input logic stop);
      logic [11:0] f;
      logic        pb;
      int          n;
      pb = fl ^ ((p == urt_pkg::PAR_EVEN) ? ^d : (p == urt_pkg::PAR_ODD) ? ~^d : 1'b0);
      f  = (p == urt_pkg::PAR_NONE) ? {2'b11, stop, d, 1'b0} : {1'b1, stop, pb, d, 1'b0};
      n  = (p == urt_pkg::PAR_NONE) ? 10 : 11;
      for (int i = 0; i < n; i++) begin
         o_rxd <= f[i];
         repeat (BT) @(posedge i_clk);
      end
      // one stop bit only, line back to idle high at once
      o_rxd <= 1'b1;
      repeat (BT) @(posedge i_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // samples mid bit; a timeout leaves garbage that the caller's compare catches
   task automatic recv(input urt_pkg::urt_par_t p, output logic [7:0] d, output logic pb,
                       output logic sb);
      int t;
      t  = 0;
      pb = 1'b0;
      while (i_txd !== 1'b0 && t < 4000) begin
         @(posedge i_clk);
         t++;
      end
      repeat (BT / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BT) @(posedge i_clk);
         d[i] = i_txd;
      end
      if (p != urt_pkg::PAR_NONE) begin
         repeat (BT) @(posedge i_clk);
         pb = i_txd;
      end
      repeat (BT) @(posedge i_clk);
      sb = i_txd;
   endtask
endmodule

// file: tb/urt_uart_tb.sv
`timescale 1ns/10ps
module urt_uart_tb;
   localparam int K  = 4;
   localparam int BT = 2 * K;
   logic        i_clk    = 1'b0;
   logic        i_resetn = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        rxd;
   logic        txd;
   logic        tdn;
   logic        rdn;
   logic        rer;
   int          n_errors        = 0;
   int          samples_checked = 0;
   int          n_tx            = 0;
   int          n_rx            = 0;
   int          n_re            = 0;

   urt_uart urt_uart_i (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd),
      .o_tx_done_irq(tdn), .o_rx_done_irq(rdn), .o_rx_error_irq(rer)
   );
   urt_remote #(.BT(BT)) urt_remote_i (.i_clk(i_clk), .i_txd(txd), .o_rxd(rxd));

   always #2.5 i_clk = ~i_clk;
   // irqs are one-cycle pulses, so count them rather than poll
   always @(posedge i_clk) begin
      n_tx += (tdn === 1'b1);
      n_rx += (rdn === 1'b1);
      n_re += (rer === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int t;
      @(posedge i_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge i_clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      n_errors += (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   // en bits: module, tx, rx, merge
   task automatic wc(input logic [3:0] en, input urt_pkg::urt_par_t p);
      apb(1'b1, urt_pkg::ADDR_CTRL, {26'h0, p, en});
   endtask
   task automatic rx_frame(input logic [7:0] d, input urt_pkg::urt_par_t p, input logic fl,
                           input logic st, input int dd, input int de);
      int a;
      int b;
      a = n_rx;
      b = n_re;
      urt_remote_i.send(d, p, fl, st);
      chk(32'(n_rx - a), 32'(dd), "rx done pulses");
      chk(32'(n_re - b), 32'(de), "rx error pulses");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      chk({31'h0, txd}, 32'h1, "txd idle");
      rdchk(urt_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
      rdchk(urt_pkg::ADDR_BAUD, 32'hff, "baud reset");
      rdchk(urt_pkg::ADDR_TXBUF, 32'hff, "txbuf reset");
      rdchk(8'h3c, 32'h0, "unmapped data");
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, urt_pkg::ADDR_BAUD, K);
      rdchk(urt_pkg::ADDR_BAUD, K, "baud write");
   endtask
   task automatic t_rx_arm;
      wc(4'b0100, urt_pkg::PAR_EVEN);
      rx_frame(8'h5a, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 0, 0);
      wc(4'b0001, urt_pkg::PAR_EVEN);
      rx_frame(8'h5a, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 0, 0);
      wc(4'b0101, urt_pkg::PAR_EVEN);
      rx_frame(8'h5a, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 1, 0);
      rdchk(urt_pkg::ADDR_RXBUF, 32'h5a, "rx data");
      rdchk(urt_pkg::ADDR_RXERR, 32'h0, "good frame status");
   endtask
   task automatic t_par;
      urt_pkg::urt_par_t m;
      for (int i = 0; i < 4; i++) begin
         m = urt_pkg::urt_par_t'(i);
         wc(4'b0101, m);
         rx_frame(8'h37, m, 1'b1, 1'b1, (i < 2), (i >= 2));
         rdchk(urt_pkg::ADDR_RXBUF, 32'h37, "errored frame kept");
         rdchk(urt_pkg::ADDR_RXERR, {31'h0, i >= 2}, "parity flag");
         rdchk(urt_pkg::ADDR_RXERR, 32'h0, "cleared by read");
      end
   endtask
   task automatic t_frm_ovr;
      wc(4'b1101, urt_pkg::PAR_EVEN);
      rx_frame(8'h81, urt_pkg::PAR_EVEN, 1'b0, 1'b0, 1, 0);
      rdchk(urt_pkg::ADDR_RXERR, 32'h2, "framing flag");
      rdchk(urt_pkg::ADDR_RXBUF, 32'h81, "framing data");
      rx_frame(8'h11, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 1, 0);
      rx_frame(8'h22, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 1, 0);
      rdchk(urt_pkg::ADDR_RXERR, 32'h4, "overrun flag");
      rdchk(urt_pkg::ADDR_RXBUF, 32'h11, "overrun frame dropped");
      wc(4'b0101, urt_pkg::PAR_EVEN);
      rx_frame(8'h33, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 1, 0);
      rx_frame(8'h44, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 0, 1);
      rdchk(urt_pkg::ADDR_RXERR, 32'h4, "overrun split irq");
      rdchk(urt_pkg::ADDR_RXBUF, 32'h33, "buffer kept");
   endtask
   task automatic t_abort;
      fork
         rx_frame(8'hc3, urt_pkg::PAR_EVEN, 1'b1, 1'b1, 0, 0);
         begin
            repeat (5 * BT) @(posedge i_clk);
            wc(4'b0001, urt_pkg::PAR_EVEN);
         end
      join
      rdchk(urt_pkg::ADDR_RXERR, 32'h0, "status kept");
      rdchk(urt_pkg::ADDR_RXBUF, 32'h33, "buffer kept on abort");
      wc(4'b0101, urt_pkg::PAR_EVEN);
      rx_frame(8'h66, urt_pkg::PAR_EVEN, 1'b0, 1'b1, 1, 0);
      rdchk(urt_pkg::ADDR_RXBUF, 32'h66, "rearmed data");
   endtask
   // two frames queued back to back in each parity mode, then the end sequence
   task automatic t_tx;
      logic [7:0]        d;
      logic              pb;
      logic              sb;
      logic [7:0]        v[2];
      int                a;
      urt_pkg::urt_par_t m;
      v = '{8'h07, 8'h0c};
      for (int i = 0; i < 4; i++) begin
         m = urt_pkg::urt_par_t'(i);
         a = n_tx;
         wc(4'b0011, m);
         fork
            for (int j = 0; j < 2; j++) begin
               urt_remote_i.recv(m, d, pb, sb);
               chk({24'h0, d}, {24'h0, v[j]}, "tx data");
               chk({31'h0, pb}, {31'h0, (m == urt_pkg::PAR_EVEN) ? ^v[j] :
                   (m == urt_pkg::PAR_ODD) ? ~^v[j] : 1'b0}, "tx parity");
               chk({31'h0, sb}, 32'h1, "tx stop");
            end
            begin
               apb(1'b1, urt_pkg::ADDR_TXBUF, {24'h0, v[0]});
               apb(1'b1, urt_pkg::ADDR_TXBUF, {24'h0, v[1]});
            end
         join
         // read while the last stop bit is still on the line
         rdchk(urt_pkg::ADDR_TXSTAT, 32'h0, "tx idle flags");
         repeat (BT) @(posedge i_clk);
         chk(32'(n_tx - a), 32'h2, "tx done pulses");
         wc(4'b0000, m);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // the run needs about 2300 cycles; the margin only cuts a hang short
   initial begin
      repeat (60000) @(posedge i_clk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs();
      t_rx_arm();
      t_par();
      t_frm_ovr();
      t_abort();
      t_tx();
      report_and_stop();
   end
endmodule
